// >>> test/gsdc_ctl_asserts.sv
// Purpose: Port checker of the command front end
// Assumes: Bound to gsdc_ctl
// Notes: Latencies counted at the pins
`timescale 1ns/1ps
module gsdc_ctl_asserts (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire gsdc_pkg::gsdc_pins_s pins_i,
  input wire gsdc_pkg::gsdc_read_s read_o,
  input wire gsdc_pkg::gsdc_pwr_e power_state_o,
  input wire logic [7:0] bank_open_o,
  input wire logic cmd_buf_en_o,
  input wire logic clk_buf_en_o
);
  import gsdc_pkg::*;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  a_cmd_buf_gate: assert property (cmd_buf_en_o == (power_state_o == PWR_ON))
    else $error("command buffers wrong");
  a_clk_buf_gate: assert property (clk_buf_en_o == (power_state_o != PWR_SELF_REF))
    else $error("clock buffers wrong");
  a_strobe_align: assert property (read_o.read_byte_strobe == {4{read_o.drive_en}})
    else $error("read strobe off its data");
  a_burst_eight: assert property ($rose(read_o.drive_en) |-> read_o.drive_en [*4] ##1 !read_o.drive_en)
    else $error("burst not eight beats");
  a_pd_entry: assert property ($rose(pins_i.clk_en_n) && power_state_o == PWR_ON |-> ##3 power_state_o != PWR_ON)
    else $error("no low power entry");
  a_pd_exit: assert property ($fell(pins_i.clk_en_n) && power_state_o != PWR_ON |-> ##3 power_state_o == PWR_ON)
    else $error("no low power exit");
  a_act_pd_kind: assert property (power_state_o == PWR_ACT_PD |-> bank_open_o != 8'h00)
    else $error("active power-down with banks idle");
  a_idle_pd_kind: assert property (power_state_o inside {PWR_PRE_PD, PWR_SELF_REF} |-> bank_open_o == 8'h00)
    else $error("idle power-down with open row");
  a_cs_mask: assert property (pins_i.cs_n [*6] |-> $stable(bank_open_o))
    else $error("deselected command acted");
  c_read: cover property ($rose(read_o.drive_en));
  c_act_pd: cover property (power_state_o == PWR_ACT_PD);
  c_self_ref: cover property (power_state_o == PWR_SELF_REF);
endmodule

// >>> test/gsdc_host_model.sv
// Purpose: Controller side pin driver
// Assumes: Tasks start just after a rising edge
// Notes: Released address and rise data lines show inverted values
`timescale 1ns/1ps
module gsdc_host_model (
  input wire logic clock_i,
  output gsdc_pkg::gsdc_pins_s pins_o
);
  import gsdc_pkg::*;
  initial begin
    pins_o = '0;
    {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} = 4'hf;
  end
  // Code is {cs_n, ras_n, cas_n, we_n}; whichever of the row strobe pin and the spare input is unused gets the wrong level
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [11:0] a);
    {pins_o.cs_n, pins_o.cas_n, pins_o.we_n} <= {c[3], c[1:0]};
    pins_o.ras_n <= c[2] ^ pins_o.mirror_select_pin;
    pins_o.mirror_spare_input <= c[2] ^ !pins_o.mirror_select_pin;
    pins_o.bank <= b;
    pins_o.addr <= a;
    @(posedge clock_i);
    pins_o.cs_n <= 1'b1;
    pins_o.addr <= ~a;
    @(posedge clock_i);
  endtask
  // One refresh, then the idle gap that spreads 8K refreshes over 32 ms
  task automatic refresh(input int gap);
    cmd(4'h1, 3'h0, 12'h000);
    repeat (gap) @(posedge clock_i);
  endtask
  // Eight beats with clock enable held low
  task automatic wr(input logic [2:0] b, input logic [31:0] d, input logic [3:0] m, input int wl);
    cmd(4'h4, b, 12'h000);
    repeat (wl - 2) @(posedge clock_i);
    for (int i = 0; i < 4; i++) begin
      pins_o.wdata_rise <= d + 32'(2 * i);
      pins_o.wdata_fall <= d + 32'(2 * i + 1);
      pins_o.write_byte_mask_rise <= m;
      pins_o.write_byte_strobe <= 4'hf;
      @(posedge clock_i);
    end
    pins_o.wdata_rise <= ~pins_o.wdata_rise;
    pins_o.write_byte_mask_rise <= 4'h0;
    pins_o.write_byte_strobe <= 4'h0;
  endtask
endmodule

// >>> test/tb_graphics_sdram_cmd_ctl.sv
// Purpose: Self-checking bench of the command front end
// Assumes: Inputs change after rising edges
// Notes: Latencies set to their upper limits
`timescale 1ns/1ps
module tb_graphics_sdram_cmd_ctl;
  import gsdc_pkg::*;
  localparam int RL = 22;
  localparam int WL = 7;
  logic clock_i, rst_i, reg_wr_i, reg_rd_i, cmd_buf_en_o, clk_buf_en_o;
  gsdc_pins_s pins;
  logic [3:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  gsdc_read_s read_o;
  gsdc_pwr_e power_state_o;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  gsdc_host_model hm_u (.clock_i, .pins_o(pins));
  gsdc_ctl dut_u (.clock_i, .rst_i, .pins_i(pins), .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .read_o, .power_state_o, .bank_open_o(), .cmd_buf_en_o, .clk_buf_en_o);
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic chk(input logic [68:0] g, input logic [68:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(negedge clock_i);
    chk(69'(reg_rdata_o), 69'(e));
    @(posedge clock_i);
  endtask
  task automatic rburst(input logic [31:0] r, input logic [31:0] f);
    hm_u.cmd(4'h5, 3'h3, 12'h000);
    repeat (RL - 2) @(posedge clock_i);
    for (int i = 0; i < 4; i++) begin
      @(negedge clock_i);
      chk(read_o, {r + 32'(2 * i), f + 32'(2 * i), 5'h1f});
    end
    @(posedge clock_i);
  endtask
  task automatic pw(input logic c, input logic [3:0] k, input logic [3:0] e);
    hm_u.pins_o.clk_en_n <= c;
    hm_u.cmd(k, 3'h5, 12'h100);
    repeat (3) @(negedge clock_i);
    chk(69'({power_state_o, cmd_buf_en_o, clk_buf_en_o}), 69'(e));
    @(posedge clock_i);
  endtask
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      results();
    end
  end
  initial begin
    rst_i = 1'b1;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0000_0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    rreg(4'h0, 32'h0000_010c);
    rreg(4'h8, 32'h0000_0000);
    wreg(4'h0, 32'h0000_0716);
    wreg(4'h0, 32'h0000_0017);
    wreg(4'h0, 32'h0000_000c);
    rreg(4'h0, 32'h0000_0716);
    $display("config test done");
    hm_u.cmd(4'h3, 3'h3, 12'h000);
    hm_u.wr(3'h3, 32'h0000_0010, 4'h0, WL);
    hm_u.wr(3'h3, 32'h5555_5500, 4'h1, WL);
    rburst(32'h5555_5510, 32'h5555_5501);
    $display("burst test done");
    hm_u.refresh(156);
    hm_u.cmd(4'hb, 3'h5, 12'h000);
    rreg(4'h4, 32'h0000_0008);
    hm_u.pins_o.mirror_select_pin <= 1'b1;
    @(posedge clock_i);
    hm_u.cmd(4'h3, 3'h5, 12'h000);
    hm_u.cmd(4'h2, 3'h3, 12'h000);
    @(posedge clock_i);
    rreg(4'h4, 32'h0000_0020);
    $display("command test done");
    pw(1'b1, 4'hf, {PWR_ACT_PD, 2'h1});
    hm_u.cmd(4'h2, 3'h5, 12'h100);
    pw(1'b0, 4'hf, {PWR_ON, 2'h3});
    rreg(4'h4, 32'h0000_0020);
    hm_u.cmd(4'h2, 3'h0, 12'h100);
    pw(1'b1, 4'h1, {PWR_SELF_REF, 2'h0});
    pw(1'b0, 4'hf, {PWR_ON, 2'h3});
    pw(1'b1, 4'hf, {PWR_PRE_PD, 2'h1});
    rreg(4'h4, 32'h0000_0100);
    pw(1'b0, 4'hf, {PWR_ON, 2'h3});
    $display("power test done");
    results();
  end
endmodule
bind gsdc_ctl gsdc_ctl_asserts chk_u (.clock_i, .rst_i, .pins_i, .read_o, .power_state_o, .bank_open_o,
  .cmd_buf_en_o, .clk_buf_en_o);

// >>> verilog/gsdc_ctl.sv
// Purpose: Command, clock-enable and strobe front end of a graphics double-data-rate DRAM
// Assumes: One clock stands for the true clock rising edge; rise and fall beats travel side by side
// Notes: Pins pass two flops, so pin-side latencies already include that delay
//
// Contract
// - Command and address sampled on the rising true clock edge
// - Read data carries two beats per clock, rise beat and fall beat
// - Clock enable low runs the device, high stops it into a low-power state
// - Stop with all banks idle picks precharge power-down or self refresh, else active
// - Clock enable sampled for entries and exits; self-refresh exit needs no command
// - Power-down ignores every input except clock and clock enable
// - Self refresh ignores every input except clock enable
// - Chip select high masks the command; it is part of the command code
// - Read latency 12 to 22 clocks, set by configuration
// - Write latency 1 to 7 clocks, set by configuration
// - Every burst is exactly eight beats
// - Eight concurrent banks of 32-bit words
// - One read strobe per byte lane, edge aligned with read data
// - Per-byte write mask keeps masked bytes from being stored
// - Mirror select high makes the row strobe pin the unused spare input
// - Mask sampled high with its beat drops that beat's byte, both edges
// - Precharge address bit 8 low picks one bank, high picks all banks
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "gsdc_map.svh"

module gsdc_ctl #(
  parameter int COL_W = 9,
  parameter int BANKS = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire gsdc_pkg::gsdc_pins_s pins_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output gsdc_pkg::gsdc_read_s read_o,
  output gsdc_pkg::gsdc_pwr_e power_state_o,
  output logic [7:0] bank_open_o,
  output logic cmd_buf_en_o,
  output logic clk_buf_en_o
);
  import gsdc_pkg::*;

  localparam int DEPTH = BANKS << COL_W;
  localparam int AW = $clog2(DEPTH);

  if (COL_W < 3 || COL_W > 9 || BANKS != 8) begin : g_bad
    $error("gsdc_ctl: COL_W must be 3..9 and BANKS 8");
  end

  typedef struct packed {
    gsdc_pins_s s1;
    gsdc_pins_s s2;
    gsdc_pwr_e pwr;
    logic [7:0] bank_open;
    logic [4:0] rl;
    logic [2:0] wl;
    logic [4:0] rd_cnt;
    logic [2:0] rd_bank;
    logic [COL_W-1:0] rd_col;
    logic [3:0] wr_cnt;
    logic [2:0] wr_bank;
    logic [COL_W-1:0] wr_col;
    gsdc_read_s rd;
    logic [31:0] rdata;
    logic cmd_en;
    logic clk_en;
  } gsdc_state_s;

  gsdc_state_s st_r;
  gsdc_state_s st_nxt;
  logic [31:0] mem [0:DEPTH-1];

  gsdc_cmd_e cmd;
  logic ras_eff;
  logic [COL_W-1:0] col_in;
  logic [AW-1:0] rd_a0;
  logic [AW-1:0] rd_a1;
  logic [AW-1:0] wr_a0;
  logic [AW-1:0] wr_a1;
  logic [1:0] rd_beat;
  logic [1:0] wr_beat;
  logic wr_go;

  // Column from A0..A7 and A9; A8 is the auto-precharge bit
  always_comb begin
    logic [8:0] col9;
    col9 = {st_r.s2.addr[9], st_r.s2.addr[7:0]};
    col_in = col9[COL_W-1:0];
  end

  // Command decode with mirror remap and chip select
  always_comb begin
    ras_eff = st_r.s2.mirror_select_pin ? st_r.s2.mirror_spare_input : st_r.s2.ras_n;
    cmd = CMD_NOP;
    if (!st_r.s2.cs_n && st_r.cmd_en) begin
      case ({ras_eff, st_r.s2.cas_n, st_r.s2.we_n})
        3'b011: cmd = CMD_ACT;
        3'b010: cmd = CMD_PRE;
        3'b101: cmd = CMD_READ;
        3'b100: cmd = CMD_WRITE;
        3'b001: cmd = CMD_REF;
        3'b000: cmd = CMD_MRS;
        default: cmd = CMD_NOP;
      endcase
    end
  end

  // Burst addresses, two words per clock
  always_comb begin
    rd_beat = 2'(`GSDC_BURST_CYC - st_r.rd_cnt[3:0]);
    wr_beat = 2'(`GSDC_BURST_CYC - st_r.wr_cnt);
    rd_a0 = {st_r.rd_bank, COL_W'(st_r.rd_col + COL_W'({rd_beat, 1'b0}))};
    rd_a1 = {st_r.rd_bank, COL_W'(st_r.rd_col + COL_W'({rd_beat, 1'b1}))};
    wr_a0 = {st_r.wr_bank, COL_W'(st_r.wr_col + COL_W'({wr_beat, 1'b0}))};
    wr_a1 = {st_r.wr_bank, COL_W'(st_r.wr_col + COL_W'({wr_beat, 1'b1}))};
    wr_go = (st_r.wr_cnt != 4'h0) && (st_r.wr_cnt <= `GSDC_BURST_CYC);
  end

  always_comb begin
    logic stop_req;
    logic [4:0] rl_w;
    logic [2:0] wl_w;
    stop_req = st_r.s2.clk_en_n;
    rl_w = reg_wdata_i[`GSDC_RL_MSB:`GSDC_RL_LSB];
    wl_w = reg_wdata_i[`GSDC_WL_MSB:`GSDC_WL_LSB];
    st_nxt = st_r;
    st_nxt.s1 = pins_i;
    st_nxt.s2 = st_r.s1;

    // Configuration port; out-of-range latencies are refused whole
    if (reg_wr_i && reg_addr_i == `GSDC_CFG_OFS) begin
      if (rl_w >= `GSDC_RL_MIN && rl_w <= `GSDC_RL_MAX && wl_w >= `GSDC_WL_MIN && wl_w <= `GSDC_WL_MAX) begin
        st_nxt.rl = rl_w;
        st_nxt.wl = wl_w;
      end
    end
    st_nxt.rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `GSDC_CFG_OFS: begin
          st_nxt.rdata[`GSDC_RL_MSB:`GSDC_RL_LSB] = st_r.rl;
          st_nxt.rdata[`GSDC_WL_MSB:`GSDC_WL_LSB] = st_r.wl;
        end
        `GSDC_STAT_OFS: begin
          st_nxt.rdata[`GSDC_ST_BANK_MSB:`GSDC_ST_BANK_LSB] = st_r.bank_open;
          st_nxt.rdata[`GSDC_ST_PWR_MSB:`GSDC_ST_PWR_LSB] = st_r.pwr;
        end
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Power state from clock enable
    case (st_r.pwr)
      PWR_ON: begin
        if (stop_req) begin
          if (cmd == CMD_REF && st_r.bank_open == 8'h00) begin
            st_nxt.pwr = PWR_SELF_REF;
          end else if (st_r.bank_open == 8'h00) begin
            st_nxt.pwr = PWR_PRE_PD;
          end else begin
            st_nxt.pwr = PWR_ACT_PD;
          end
        end
      end
      PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF: begin
        if (!stop_req) begin
          st_nxt.pwr = PWR_ON;
        end
      end
      default: st_nxt.pwr = PWR_ON;
    endcase
    st_nxt.cmd_en = (st_nxt.pwr == PWR_ON);
    st_nxt.clk_en = (st_nxt.pwr != PWR_SELF_REF);

    // Bank bookkeeping and burst launch; a command taken with the stop is still honoured
    case (cmd)
      CMD_ACT: st_nxt.bank_open[st_r.s2.bank] = 1'b1;
      CMD_PRE: begin
        if (st_r.s2.addr[`GSDC_PRE_ALL_BIT]) begin
          st_nxt.bank_open = 8'h00;
        end else begin
          st_nxt.bank_open[st_r.s2.bank] = 1'b0;
        end
      end
      CMD_READ: begin
        if (st_r.bank_open[st_r.s2.bank]) begin
          st_nxt.rd_cnt = st_r.rl;
          st_nxt.rd_bank = st_r.s2.bank;
          st_nxt.rd_col = col_in;
          if (st_r.s2.addr[`GSDC_PRE_ALL_BIT]) begin
            st_nxt.bank_open[st_r.s2.bank] = 1'b0;
          end
        end
      end
      CMD_WRITE: begin
        if (st_r.bank_open[st_r.s2.bank]) begin
          st_nxt.wr_cnt = 4'({1'b0, st_r.wl} + `GSDC_WR_EXTRA);
          st_nxt.wr_bank = st_r.s2.bank;
          st_nxt.wr_col = col_in;
          if (st_r.s2.addr[`GSDC_PRE_ALL_BIT]) begin
            st_nxt.bank_open[st_r.s2.bank] = 1'b0;
          end
        end
      end
      default: st_nxt.bank_open = st_nxt.bank_open;
    endcase

    // Read beats: four clocks of rise and fall words, eight beats in all
    if (st_r.rd_cnt != 5'h00 && cmd != CMD_READ) begin
      st_nxt.rd_cnt = st_r.rd_cnt - 5'h01;
    end
    st_nxt.rd = '0;
    if (st_r.rd_cnt != 5'h00 && st_r.rd_cnt <= 5'(`GSDC_BURST_CYC)) begin
      st_nxt.rd.data_rise = mem[rd_a0];
      st_nxt.rd.data_fall = mem[rd_a1];
      st_nxt.rd.read_byte_strobe = 4'hf;
      st_nxt.rd.drive_en = 1'b1;
    end
    if (st_r.wr_cnt != 4'h0 && cmd != CMD_WRITE) begin
      st_nxt.wr_cnt = st_r.wr_cnt - 4'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.s1.clk_en_n <= 1'b1;
      st_r.s2.clk_en_n <= 1'b1;
      st_r.s1.cs_n <= 1'b1;
      st_r.s2.cs_n <= 1'b1;
      st_r.pwr <= PWR_ON;
      st_r.rl <= `GSDC_RL_RST;
      st_r.wl <= `GSDC_WL_RST;
      st_r.cmd_en <= 1'b1;
      st_r.clk_en <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Write beats with per-byte mask on both edges
  always_ff @(posedge clock_i) begin
    if (wr_go) begin
      for (int b = 0; b < 4; b++) begin
        if (!st_r.s2.write_byte_mask_rise[b]) begin
          mem[wr_a0][b*8 +: 8] <= st_r.s2.wdata_rise[b*8 +: 8];
        end
        if (!st_r.s2.write_byte_mask_fall[b]) begin
          mem[wr_a1][b*8 +: 8] <= st_r.s2.wdata_fall[b*8 +: 8];
        end
      end
    end
  end

  assign reg_rdata_o = st_r.rdata;
  assign read_o = st_r.rd;
  assign power_state_o = st_r.pwr;
  assign bank_open_o = st_r.bank_open;
  assign cmd_buf_en_o = st_r.cmd_en;
  assign clk_buf_en_o = st_r.clk_en;

endmodule

// >>> verilog/gsdc_map.svh
// Purpose: Offsets, field positions, reset values and counts of the command front end
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef GSDC_MAP_SVH
`define GSDC_MAP_SVH

`define GSDC_CFG_OFS 4'h0
`define GSDC_STAT_OFS 4'h4
`define GSDC_RL_LSB 0
`define GSDC_RL_MSB 4
`define GSDC_WL_LSB 8
`define GSDC_WL_MSB 10
`define GSDC_ST_BANK_LSB 0
`define GSDC_ST_BANK_MSB 7
`define GSDC_ST_PWR_LSB 8
`define GSDC_ST_PWR_MSB 9
`define GSDC_RL_RST 5'h0c
`define GSDC_WL_RST 3'h1
`define GSDC_RL_MIN 5'h0c
`define GSDC_RL_MAX 5'h16
`define GSDC_WL_MIN 3'h1
`define GSDC_WL_MAX 3'h7
`define GSDC_BURST_BEATS 8
`define GSDC_BURST_CYC 4'h4
`define GSDC_WR_EXTRA 4'h3
`define GSDC_PRE_ALL_BIT 8

`endif

// >>> verilog/gsdc_pkg.sv
// Purpose: Types of the command front end
// Assumes: Constants come from gsdc_map.svh
// Notes: Pin groups travel as packed structs
package gsdc_pkg;

  typedef enum logic [1:0] {
    PWR_ON,
    PWR_PRE_PD,
    PWR_ACT_PD,
    PWR_SELF_REF
  } gsdc_pwr_e;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_PRE,
    CMD_READ,
    CMD_WRITE,
    CMD_REF,
    CMD_MRS
  } gsdc_cmd_e;

  // Pins arriving from the controller
  typedef struct packed {
    logic clk_en_n;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic mirror_spare_input;
    logic mirror_select_pin;
    logic [2:0] bank;
    logic [11:0] addr;
    logic [31:0] wdata_rise;
    logic [31:0] wdata_fall;
    logic [3:0] write_byte_mask_rise;
    logic [3:0] write_byte_mask_fall;
    logic [3:0] write_byte_strobe;
  } gsdc_pins_s;

  // Read data beats of one clock, rise beat then fall beat
  typedef struct packed {
    logic [31:0] data_rise;
    logic [31:0] data_fall;
    logic [3:0] read_byte_strobe;
    logic drive_en;
  } gsdc_read_s;

endpackage
